/* File: logic/pfjc_pipeline.sv */
// Purpose: Control of a fetch, decode, execute, write back pipeline with a jump cache
// Assumes: Code memory answers fetch_addr within the same cycle; decoder reads dec_slot
// Notes: bus_hold freezes every stage; pointer writes land in execute
//
// What this block does
// RULE1: Every instruction passes all four stages
// RULE2: Four in flight, one completes per cycle
// RULE3: Taken branch drops prefetch, injects filler
// RULE4: Untaken conditional branch costs no cycle
// RULE5: First taken cache jump refetches, saves target
// RULE6: Only six conditional jumps use the cache
// RULE7: Cache hit injects target straight into decode
// RULE8: Segment changes and interrupts invalidate cache
// RULE9: Forward operand values between stages
// RULE10: Next instruction may miss new context pointer
// RULE11: Next instruction may miss new page pointer
// RULE12: Pop right after stack write uses old
// RULE13: Bus grants: writes, then code, then reads
// RULE14: Decode addresses, stack adjust, branch target load
// RULE15: Execute pointer writes; write back stores operands
// RULE16: Injected instructions enter decode, carry interrupts
// RULE17: One cache entry, replaced by another jump
`timescale 1ns/100ps
`default_nettype none
module pfjc_pipeline (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_hold,
	input wire logic [pfjc_pkg::INSTR_W-1:0] fetch_instr,
	input wire pfjc_pkg::pfjc_dec_s dec_info,
	input wire logic [pfjc_pkg::DATA_W-1:0] rf_rdata,
	input wire logic [pfjc_pkg::DATA_W-1:0] ex_wdata,
	input wire logic irq_req,
	input wire logic [pfjc_pkg::ADDR_W-1:0] irq_vector,
	input wire pfjc_pkg::pfjc_bus_s bus_req,
	output logic [pfjc_pkg::CSP_W-1:0] code_segment_pointer,
	output logic [pfjc_pkg::IP_W-1:0] instruction_pointer,
	output pfjc_pkg::pfjc_slot_s dec_slot,
	output pfjc_pkg::pfjc_slot_s ex_slot,
	output pfjc_pkg::pfjc_slot_s wb_slot,
	output logic [pfjc_pkg::DATA_W-1:0] context_pointer,
	output logic [pfjc_pkg::DPP_NUM-1:0][pfjc_pkg::DATA_W-1:0] data_page_pointer,
	output logic [pfjc_pkg::DATA_W-1:0] stack_pointer,
	output logic irq_ack,
	output logic [pfjc_pkg::ADDR_W-1:0] irq_ret_addr,
	output pfjc_pkg::pfjc_bus_s bus_grant
);
	logic [pfjc_pkg::ADDR_W-1:0] fetch_addr;
	logic fill_pend;
	logic [pfjc_pkg::ADDR_W-1:0] fill_tag;
	logic [pfjc_pkg::ADDR_W-1:0] next_fetch_addr;
	logic next_fill_pend;
	logic [pfjc_pkg::ADDR_W-1:0] next_fill_tag;
	pfjc_pkg::pfjc_slot_s next_dec_slot;
	pfjc_pkg::pfjc_slot_s next_ex_slot;
	pfjc_pkg::pfjc_slot_s next_wb_slot;
	logic [pfjc_pkg::DATA_W-1:0] next_context_pointer;
	logic [pfjc_pkg::DPP_NUM-1:0][pfjc_pkg::DATA_W-1:0] next_data_page_pointer;
	logic [pfjc_pkg::DATA_W-1:0] next_stack_pointer;
	logic next_irq_ack;
	logic [pfjc_pkg::ADDR_W-1:0] next_irq_ret_addr;
	pfjc_pkg::pfjc_bus_s next_bus_grant;

	logic dec_live;
	logic is_cache_jump;
	logic is_branch;
	logic taken;
	logic cache_hit;
	logic [pfjc_pkg::INSTR_W-1:0] cache_instr;
	logic cache_wr;
	logic cache_inv;
	logic [pfjc_pkg::DATA_W-1:0] operand;
	pfjc_pkg::pfjc_slot_s fetched;
	pfjc_pkg::pfjc_slot_s filler;

	pfjc_jump_cache #(
		.ADDR_W(pfjc_pkg::ADDR_W),
		.INSTR_W(pfjc_pkg::INSTR_W)
	) u_cache (
		.clk(clk),
		.reset(reset),
		.lookup_addr(dec_slot.addr),
		.hit(cache_hit),
		.hit_instr(cache_instr),
		.wr_en(cache_wr),
		.wr_tag(fill_tag),
		.wr_instr(fetch_instr),
		.inv(cache_inv)
	);

	// Injected slots ignore the decoder, so a filler never branches by accident
	assign dec_live = dec_slot.valid && !dec_slot.inj;
	always_comb begin
		is_cache_jump = 1'b0;
		case (dec_info.op)
			pfjc_pkg::PFJC_OP_ABS_COND_JUMP,
			pfjc_pkg::PFJC_OP_REL_COND_JUMP,
			pfjc_pkg::PFJC_OP_JUMP_IF_BIT_SET,
			pfjc_pkg::PFJC_OP_JUMP_IF_BIT_SET_THEN_CLEAR,
			pfjc_pkg::PFJC_OP_JUMP_IF_BIT_CLEAR,
			pfjc_pkg::PFJC_OP_JUMP_IF_BIT_CLEAR_THEN_SET: is_cache_jump = 1'b1; // [RULE6]
			default: is_cache_jump = 1'b0;
		endcase
	end
	assign is_branch = is_cache_jump || (dec_info.op == pfjc_pkg::PFJC_OP_BRANCH)
		|| (dec_info.op == pfjc_pkg::PFJC_OP_SEGMENT_CHANGE);
	assign taken = dec_live && is_branch && dec_info.cond_met;

	always_comb begin
		fetched = '0;
		fetched.valid = 1'b1;
		fetched.addr = fetch_addr;
		fetched.instr = fetch_instr;
		filler = '0;
		filler.valid = 1'b1;
		filler.inj = 1'b1;
		filler.addr = fetch_addr;
		filler.instr = pfjc_pkg::INJECT_INSTR;
	end

	// Youngest writer wins so a back-to-back dependency sees the newest value
	always_comb begin
		operand = rf_rdata;
		if (ex_slot.valid && ex_slot.wr && (ex_slot.waddr == dec_info.rd_addr)) begin
			operand = ex_wdata; // [RULE9]
		end else if (wb_slot.valid && wb_slot.wr && (wb_slot.waddr == dec_info.rd_addr)) begin
			operand = wb_slot.data; // [RULE9]
		end
	end

	always_comb begin
		next_fetch_addr = fetch_addr;
		next_fill_pend = fill_pend;
		next_fill_tag = fill_tag;
		next_dec_slot = dec_slot;
		next_ex_slot = ex_slot;
		next_wb_slot = wb_slot;
		next_context_pointer = context_pointer;
		next_data_page_pointer = data_page_pointer;
		next_stack_pointer = stack_pointer;
		next_irq_ack = 1'b0;
		next_irq_ret_addr = irq_ret_addr;
		cache_wr = 1'b0;
		cache_inv = 1'b0;
		if (!bus_hold) begin
			// Each slot moves one stage per cycle, none is skipped
			next_wb_slot = ex_slot; // [RULE1] [RULE2]
			next_wb_slot.data = ex_wdata; // [RULE15]
			next_ex_slot = dec_slot; // [RULE1] [RULE16]
			if (dec_live) begin
				next_ex_slot.op = dec_info.op;
				next_ex_slot.sel = dec_info.sel;
				next_ex_slot.wr = dec_info.wr;
				next_ex_slot.waddr = dec_info.waddr;
				next_ex_slot.data = operand; // [RULE14]
				if (dec_info.sp_inc) begin
					next_stack_pointer = stack_pointer + pfjc_pkg::SP_STEP; // [RULE14]
				end else if (dec_info.sp_dec) begin
					next_stack_pointer = stack_pointer - pfjc_pkg::SP_STEP; // [RULE14]
				end
			end
			next_dec_slot = fetched; // [RULE2] [RULE4]
			next_fetch_addr = fetch_addr + pfjc_pkg::INSTR_STEP;
			if (fill_pend) begin
				// Target arrives from fetch in the cycle the filler decodes
				cache_wr = 1'b1; // [RULE5] [RULE17]
				next_fill_pend = 1'b0;
			end
			if (taken) begin
				if (is_cache_jump && cache_hit) begin
					next_dec_slot = fetched;
					next_dec_slot.addr = dec_info.target;
					next_dec_slot.instr = cache_instr; // [RULE7]
					next_fetch_addr = dec_info.target + pfjc_pkg::INSTR_STEP; // [RULE7]
				end else begin
					next_dec_slot = filler; // [RULE3]
					next_fetch_addr = dec_info.target; // [RULE3] [RULE14]
					if (is_cache_jump) begin
						next_fill_pend = 1'b1; // [RULE5]
						next_fill_tag = dec_slot.addr; // [RULE17]
					end
				end
			end else if (irq_req && !dec_slot.inj) begin
				// Prefetched word is dropped and becomes the return point
				next_dec_slot = filler; // [RULE16]
				next_fetch_addr = irq_vector;
				next_irq_ret_addr = fetch_addr;
				next_irq_ack = 1'b1;
				cache_inv = 1'b1; // [RULE8]
				next_fill_pend = 1'b0;
			end
			if (dec_live && (dec_info.op == pfjc_pkg::PFJC_OP_SEGMENT_CHANGE)) begin
				cache_inv = 1'b1; // [RULE8]
				next_fill_pend = 1'b0;
			end
			// Pointer writes land in execute while the next one already decodes
			if (ex_slot.valid && !ex_slot.inj) begin
				case (ex_slot.op)
					pfjc_pkg::PFJC_OP_CP_WRITE: next_context_pointer = ex_wdata; // [RULE10] [RULE15]
					pfjc_pkg::PFJC_OP_DPP_WRITE: next_data_page_pointer[ex_slot.sel] = ex_wdata; // [RULE11]
					pfjc_pkg::PFJC_OP_SP_WRITE: next_stack_pointer = ex_wdata; // [RULE12] [RULE15]
					default: next_context_pointer = context_pointer;
				endcase
			end
		end
		next_bus_grant = '0;
		if (bus_req.wr) begin
			next_bus_grant.wr = 1'b1; // [RULE13]
		end else if (bus_req.code) begin
			next_bus_grant.code = 1'b1; // [RULE13]
		end else if (bus_req.rd) begin
			next_bus_grant.rd = 1'b1; // [RULE13]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fetch_addr <= pfjc_pkg::RESET_ADDR;
			fill_pend <= 1'b0;
			fill_tag <= '0;
			dec_slot <= '0;
			ex_slot <= '0;
			wb_slot <= '0;
			context_pointer <= pfjc_pkg::RESET_CP;
			data_page_pointer <= {pfjc_pkg::DPP_NUM{pfjc_pkg::RESET_DPP}};
			stack_pointer <= pfjc_pkg::RESET_SP;
			irq_ack <= 1'b0;
			irq_ret_addr <= '0;
			bus_grant <= '0;
		end else begin
			fetch_addr <= next_fetch_addr;
			fill_pend <= next_fill_pend;
			fill_tag <= next_fill_tag;
			dec_slot <= next_dec_slot;
			ex_slot <= next_ex_slot;
			wb_slot <= next_wb_slot;
			context_pointer <= next_context_pointer;
			data_page_pointer <= next_data_page_pointer;
			stack_pointer <= next_stack_pointer;
			irq_ack <= next_irq_ack;
			irq_ret_addr <= next_irq_ret_addr;
			bus_grant <= next_bus_grant;
		end
	end

	assign code_segment_pointer = fetch_addr[pfjc_pkg::ADDR_W-1:pfjc_pkg::IP_W];
	assign instruction_pointer = fetch_addr[pfjc_pkg::IP_W-1:0];
endmodule
`default_nettype wire

/* File: pkg/pfjc_pkg.sv */
// Purpose: Shared types and constants of the four-stage pipeline control with jump cache
// Assumes: One machine cycle per clock; decoder, ALU and bus protocol live outside
// Notes: Code addresses are segment and offset joined, segment in the upper bits
package pfjc_pkg;
	localparam int IP_W = 16;
	localparam int CSP_W = 8;
	localparam int ADDR_W = CSP_W + IP_W;
	localparam int INSTR_W = 32;
	localparam int DATA_W = 16;
	localparam int RADDR_W = 16;
	localparam int DPP_NUM = 4;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
	localparam logic [ADDR_W-1:0] INSTR_STEP = 24'h000004;
	localparam logic [DATA_W-1:0] SP_STEP = 16'h0002;
	localparam logic [DATA_W-1:0] RESET_SP = 16'h0000;
	localparam logic [DATA_W-1:0] RESET_CP = 16'h0000;
	localparam logic [DATA_W-1:0] RESET_DPP = 16'h0000;
	localparam logic [INSTR_W-1:0] INJECT_INSTR = 32'h00000000;

	typedef enum logic [3:0] {
		PFJC_OP_PLAIN = 4'b0000,
		PFJC_OP_ABS_COND_JUMP = 4'b0001,
		PFJC_OP_REL_COND_JUMP = 4'b0010,
		PFJC_OP_JUMP_IF_BIT_SET = 4'b0011,
		PFJC_OP_JUMP_IF_BIT_SET_THEN_CLEAR = 4'b0100,
		PFJC_OP_JUMP_IF_BIT_CLEAR = 4'b0101,
		PFJC_OP_JUMP_IF_BIT_CLEAR_THEN_SET = 4'b0110,
		PFJC_OP_BRANCH = 4'b0111,
		PFJC_OP_SEGMENT_CHANGE = 4'b1000,
		PFJC_OP_CP_WRITE = 4'b1001,
		PFJC_OP_DPP_WRITE = 4'b1010,
		PFJC_OP_SP_WRITE = 4'b1011
	} pfjc_op_e;

	// What the outside decoder reports for the instruction held in decode
	typedef struct packed {
		pfjc_op_e op;
		logic cond_met;
		logic [ADDR_W-1:0] target;
		logic [1:0] sel;
		logic wr;
		logic [RADDR_W-1:0] waddr;
		logic [RADDR_W-1:0] rd_addr;
		logic sp_inc;
		logic sp_dec;
	} pfjc_dec_s;

	typedef struct packed {
		logic valid;
		logic inj;
		logic [ADDR_W-1:0] addr;
		logic [INSTR_W-1:0] instr;
		pfjc_op_e op;
		logic [1:0] sel;
		logic wr;
		logic [RADDR_W-1:0] waddr;
		logic [DATA_W-1:0] data;
	} pfjc_slot_s;

	typedef struct packed {
		logic wr;
		logic code;
		logic rd;
	} pfjc_bus_s;
endpackage

/* File: logic/pfjc_jump_cache.sv */
// Purpose: Single-entry jump cache: jump address tag, valid flag, target instruction
// Assumes: Lookup is combinational from the stored entry
// Notes: Invalidate beats a write landing in the same cycle
`timescale 1ns/100ps
`default_nettype none
module pfjc_jump_cache #(
	parameter int ADDR_W = 24,
	parameter int INSTR_W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] lookup_addr,
	output logic hit,
	output logic [INSTR_W-1:0] hit_instr,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_tag,
	input wire logic [INSTR_W-1:0] wr_instr,
	input wire logic inv
);
	logic valid;
	logic [ADDR_W-1:0] tag;
	logic [INSTR_W-1:0] data;
	logic next_valid;
	logic [ADDR_W-1:0] next_tag;
	logic [INSTR_W-1:0] next_data;

	always_comb begin
		next_valid = valid;
		next_tag = tag;
		next_data = data;
		if (wr_en) begin
			next_valid = 1'b1;
			next_tag = wr_tag;
			next_data = wr_instr;
		end
		if (inv) begin
			next_valid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			valid <= 1'b0;
			tag <= '0;
			data <= '0;
		end else begin
			valid <= next_valid;
			tag <= next_tag;
			data <= next_data;
		end
	end

	assign hit = valid && (tag == lookup_addr);
	assign hit_instr = data;
endmodule
`default_nettype wire

/* File: tb/pfjc_monitor.sv */
// Purpose: Port checks on the pipeline control
// Assumes: One clock, asynchronous active-high reset
// Notes: Branch and cache flow are judged by the bench model
`timescale 1ns/100ps
`default_nettype none
module pfjc_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_hold,
	input wire pfjc_pkg::pfjc_dec_s dec_info,
	input wire logic [15:0] ex_wdata,
	input wire logic [23:0] irq_vector,
	input wire logic irq_ack,
	input wire pfjc_pkg::pfjc_bus_s bus_req,
	input wire pfjc_pkg::pfjc_bus_s bus_grant,
	input wire logic [7:0] code_segment_pointer,
	input wire logic [15:0] instruction_pointer,
	input wire pfjc_pkg::pfjc_slot_s dec_slot,
	input wire pfjc_pkg::pfjc_slot_s ex_slot,
	input wire pfjc_pkg::pfjc_slot_s wb_slot,
	input wire logic [15:0] context_pointer,
	input wire logic [3:0][15:0] data_page_pointer,
	input wire logic [15:0] stack_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic ex_go = !bus_hold && ex_slot.valid && !ex_slot.inj;
	wire logic dec_go = !bus_hold && dec_slot.valid && !dec_slot.inj;
	wire logic sp_wr = ex_go && ex_slot.op == pfjc_pkg::PFJC_OP_SP_WRITE;
	property p_ex_follow;
		!bus_hold |=> ex_slot.valid == $past(dec_slot.valid) && ex_slot.addr == $past(dec_slot.addr);
	endproperty
	a_ex_follow: assert property (p_ex_follow) else $error("ex slot lost");
	property p_wb_follow;
		!bus_hold |=> wb_slot.valid == $past(ex_slot.valid) && wb_slot.addr == $past(ex_slot.addr);
	endproperty
	a_wb_follow: assert property (p_wb_follow) else $error("wb slot lost");
	property p_freeze;
		bus_hold |=> $stable(dec_slot) && $stable(ex_slot) && $stable(instruction_pointer);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved under hold");
	property p_grant;
		1 |=> bus_grant == ($past(bus_req.wr) ? 3'h4 : $past(bus_req.code) ? 3'h2 : {2'h0, $past(bus_req.rd)});
	endproperty
	a_grant: assert property (p_grant) else $error("grant order");
	property p_irq;
		irq_ack |-> dec_slot.inj && {code_segment_pointer, instruction_pointer} == irq_vector ##1 !irq_ack;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt entry");
	property p_cp;
		ex_go && ex_slot.op == pfjc_pkg::PFJC_OP_CP_WRITE |=> context_pointer == $past(ex_wdata);
	endproperty
	a_cp: assert property (p_cp) else $error("context write");
	property p_dpp;
		ex_go && ex_slot.op == pfjc_pkg::PFJC_OP_DPP_WRITE |=> data_page_pointer[$past(ex_slot.sel)] == $past(ex_wdata);
	endproperty
	a_dpp: assert property (p_dpp) else $error("page write");
	property p_sp;
		sp_wr |=> stack_pointer == $past(ex_wdata);
	endproperty
	a_sp: assert property (p_sp) else $error("stack write");
	property p_sp_adj;
		dec_go && dec_info.sp_inc && !dec_info.sp_dec && !sp_wr |=> stack_pointer == $past(stack_pointer) + 16'h0002;
	endproperty
	a_sp_adj: assert property (p_sp_adj) else $error("stack adjust");
	property p_fwd;
		dec_go && ex_go && ex_slot.wr && ex_slot.waddr == dec_info.rd_addr |=> ex_slot.data == $past(ex_wdata);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forwarding");
	c_ack: cover property (irq_ack);
	c_all_req: cover property (bus_req == 3'h7);
	c_adj: cover property (dec_go && dec_info.sp_inc);
endmodule
bind pfjc_pipeline pfjc_monitor pfjc_monitor_inst (.*);
`default_nettype wire

/* File: tb/pfjc_ebc_model.sv */
// Purpose: Code memory and bus controller facing the pipeline
// Assumes: Code word answers the fetch address in the same cycle
// Notes: A granted write occupies the bus, so the core is held one cycle
`timescale 1ns/100ps
`default_nettype none
module pfjc_ebc_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [23:0] fetch_addr,
	input wire pfjc_pkg::pfjc_bus_s bus_grant,
	output logic [31:0] fetch_instr,
	output logic bus_hold
);
	// Word: target in 31:8, wr 7, stack pop 6, unconditional 5, cond 4, op 3:0
	function automatic logic [31:0] word(input logic [23:0] a);
		case (a)
			24'h04: word = 32'h00000009;
			24'h08: word = 32'h0000020A;
			24'h0C: word = 32'h0000000B;
			24'h10: word = 32'h00004011;
			24'h14: word = 32'h00004037;
			24'h44: word = 32'h000000C0;
			24'h48: word = 32'h00004012;
			default: word = {a, 8'h80};
		endcase
	endfunction
	always_comb fetch_instr = word(fetch_addr);
	always @(posedge clk or posedge reset) begin
		if (reset) bus_hold <= 1'b0;
		else bus_hold <= bus_grant.wr & ~bus_hold;
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the pipeline control
// Assumes: Bench decodes the code words of the bus model
// Notes: Model tracks decode contents; -1 is filler, -2 empty
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", n, e, s); end end
module testbench;
	logic clk = 1'b0, reset = 1'b1, irq_req = 1'b0, take = 1'b0, bus_hold, irq_ack;
	logic [31:0] fetch_instr, w;
	logic [15:0] rf_rdata = 16'h0000, ex_wdata = 16'h0000;
	logic [15:0] instruction_pointer, context_pointer, stack_pointer;
	logic [23:0] irq_vector = 24'h000040, irq_ret_addr;
	logic [7:0] code_segment_pointer;
	logic [3:0][15:0] data_page_pointer;
	logic [3:0] jop = 4'h2, o;
	pfjc_pkg::pfjc_dec_s dec_info;
	pfjc_pkg::pfjc_bus_s bus_req = 3'h0, bus_grant;
	pfjc_pkg::pfjc_slot_s dec_slot, ex_slot, wb_slot;
	int mismatches = 0, checked = 0, lfsr = 19, q[$] = '{-2, -2, -2};
	int nf = 0, nxt, tag = -1, gnt = 0, ack = 0, ret;
	pfjc_pipeline pfjc_pipeline_inst (.*);
	pfjc_ebc_model mem_inst (.clk, .reset, .fetch_addr({code_segment_pointer, instruction_pointer}),
		.bus_grant, .fetch_instr, .bus_hold);
	always_comb begin
		dec_info = '0;
		dec_info.op = pfjc_pkg::pfjc_op_e'(dec_slot.instr[3:0] == 4'h2 ? jop : dec_slot.instr[3:0]);
		dec_info.cond_met = dec_slot.instr[4] & (take | dec_slot.instr[5]);
		dec_info.target = dec_slot.instr[31:8];
		dec_info.sel = dec_slot.instr[9:8];
		dec_info.wr = dec_slot.instr[7];
		dec_info.sp_inc = dec_slot.instr[6];
	end
	function automatic int next_rand(input int v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk_slot(input string n, input pfjc_pkg::pfjc_slot_s s, input int e);
		if (e == -1) `CHK(n, 1'b1, s.inj)
		else if (e == -2) `CHK(n, 1'b0, s.valid)
		else `CHK(n, e + 32'h1000000, {s.valid, s.addr})
	endtask
	task automatic end_sim;
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		lfsr = next_rand(lfsr);
		ex_wdata <= lfsr[15:0];
		bus_req <= lfsr[18:16];
		rf_rdata <= lfsr[31:16];
		if (irq_ack) irq_req <= 1'b0;
	end
	always @(posedge clk) if (!reset) begin
		gnt = bus_req.wr ? 4 : bus_req.code ? 2 : bus_req.rd;
		ack = 0;
		if (!bus_hold) begin
			w = mem_inst.word(q[$]);
			o = w[3:0] == 4'h2 ? jop : w[3:0];
			nxt = nf;
			nf = nf + 4;
			if (q[$] >= 0 && w[4] && (take || w[5]) && o > 0 && o < 9) begin
				// Only a conditional cache jump may reuse its stored target
				nxt = (o < 7 && tag == q[$]) ? w[31:8] : -1;
				nf = nxt < 0 ? w[31:8] : w[31:8] + 4;
				if (o < 7) tag = q[$];
				else if (o == 8) tag = -1;
			end else if (q[$] >= 0 && irq_req) begin
				nxt = -1;
				ret = nf - 4;
				nf = irq_vector;
				tag = -1;
				ack = 1;
			end
			q.push_back(nxt);
		end
	end
	always @(negedge clk) if (!reset) begin
		chk_slot("dec", dec_slot, q[$]);
		chk_slot("ex", ex_slot, q[$-1]);
		chk_slot("wb", wb_slot, q[$-2]);
		`CHK("grant", gnt, bus_grant)
		`CHK("ack", ack, irq_ack)
		if (ack) `CHK("ret", ret, irq_ret_addr)
	end
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (2) begin
			take <= 1'b0;
			repeat (40) @(posedge clk);
			take <= 1'b1;
			irq_req <= 1'b1;
			for (int k = 1; k < 9; k++) begin
				jop <= k[3:0];
				repeat (10) @(posedge clk);
			end
			jop <= 4'h2;
		end
		end_sim();
	end
	// Whole run is about 244 cycles; over three times that is a hang
	initial begin
		#32000;
		mismatches++;
		end_sim();
	end
endmodule
`default_nettype wire
